// [pts_top.v]
// Pulse train servo I/O: pin decode, deviation, homing, alarms, APB registers
//
// Our own choices: the register offsets and register access over APB.
`include "pts_defs.vh"
module pts_top #(
   parameter        DEV_W     = 24,
   parameter [19:0] SPEED_WIN = `PTS_SPEED_WIN_CYC
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        step_in_pos,
   input  wire        step_in_neg,
   input  wire        heading_in_pos,
   input  wire        heading_in_neg,
   input  wire        homing_request,
   input  wire        alarm_reset_input,
   input  wire        drive_enable_input,
   input  wire        feedback_a,
   input  wire        feedback_b,
   input  wire        home_sensor_in,
   input  wire        sensor_fault_in,
   input  wire        cpu_fault_in,
   output reg         homing_done,
   output reg         homing_active,
   output reg         in_position,
   output reg         fault_n,
   output reg         drive_enabled_flag,
   output reg         motor_drive_on,
   output reg         irq
);

   localparam [1:0] H_IDLE = 2'h0;
   localparam [1:0] H_SEEK = 2'h1;
   localparam [1:0] H_DONE = 2'h2;
   localparam [19:0] WIN_END = SPEED_WIN - 20'h00001;

   function [DEV_W-1:0] mag;
      input [DEV_W-1:0] v;
      begin
         mag = v[DEV_W-1] ? (~v + 1'b1) : v;
      end
   endfunction

   // ==========================================================
   // Pin synchronisers
   wire [11:0] pin_s;
   pts_sync #(.W(12)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({step_in_pos, step_in_neg, heading_in_pos, heading_in_neg,
                 homing_request, alarm_reset_input, drive_enable_input,
                 feedback_a, feedback_b, home_sensor_in, sensor_fault_in,
                 cpu_fault_in}),
      .q       (pin_s)
   );
   wire step_p_s  = pin_s[11];
   wire step_n_s  = pin_s[10];
   wire head_p_s  = pin_s[9];
   wire head_n_s  = pin_s[8];
   wire home_rq_s = pin_s[7];
   wire arst_s    = pin_s[6];
   wire enable_s  = pin_s[5];
   wire fb_a_s    = pin_s[4];
   wire fb_b_s    = pin_s[3];
   wire home_s    = pin_s[2];
   wire posdet_s  = pin_s[1];
   wire cpu_s     = pin_s[0];

   // ==========================================================
   // Registers
   reg  [31:0]      ctrl;
   reg  [31:0]      inpos_tol;
   reg  [31:0]      dev_limit;
   reg  [31:0]      spd_limit;
   reg  [31:0]      irq_mask;
   reg  [2:0]       irq_stat;
   reg  [4:0]       fault_lat;
   reg  [1:0]       hstate;
   reg  [DEV_W-1:0] dev;
   reg              arst_d;

   wire single = ctrl[`PTS_CTRL_SE];
   // Open-collector inputs pull low when active, so the negative pin is inverted
   wire cmd_a  = single ? ~step_n_s : step_p_s;
   wire cmd_b  = single ? ~head_n_s : head_p_s;

   // ==========================================================
   // Decoders
   wire cmd_step;
   wire cmd_dir;
   wire fb_step;
   wire fb_dir;
   pts_decode u_cmd (
      .pclk    (pclk),
      .presetn (presetn),
      .fmt     (ctrl[`PTS_CTRL_FMT_HI:`PTS_CTRL_FMT_LO]),
      .a       (cmd_a),
      .b       (cmd_b),
      .step    (cmd_step),
      .dir     (cmd_dir)
   );
   pts_decode u_fb (
      .pclk    (pclk),
      .presetn (presetn),
      .fmt     (`PTS_FMT_QUAD),
      .a       (fb_a_s),
      .b       (fb_b_s),
      .step    (fb_step),
      .dir     (fb_dir)
   );

   // ==========================================================
   // Deviation counter
   // Commands are ignored while homing, since the search owns the motion
   wire             accept  = cmd_step & motor_drive_on & (hstate != H_SEEK);
   wire [DEV_W-1:0] cmd_inc = accept ? (cmd_dir ? {{(DEV_W-1){1'b0}}, 1'b1}
                                                : {DEV_W{1'b1}}) : {DEV_W{1'b0}};
   wire [DEV_W-1:0] fb_inc  = fb_step ? (fb_dir ? {{(DEV_W-1){1'b0}}, 1'b1}
                                                : {DEV_W{1'b1}}) : {DEV_W{1'b0}};
   wire [31:0]      dev_mag = {{(32-DEV_W){1'b0}}, mag(dev)};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dev <= {DEV_W{1'b0}};
      end else if (!motor_drive_on) begin
         dev <= {DEV_W{1'b0}};
      end else begin
         dev <= dev + cmd_inc - fb_inc;
      end
   end

   // ==========================================================
   // Pulse frequency and command speed monitors
   reg  [9:0]  gap;
   reg         seen;
   reg  [19:0] win_cnt;
   reg  [15:0] pcnt;
   wire [31:0] min_gap  = single ? `PTS_SE_MIN_CYC : `PTS_DIFF_MIN_CYC;
   wire        freq_evt = cmd_step & seen & ({22'h000000, gap} < min_gap);
   wire        spd_evt  = cmd_step & ({16'h0000, pcnt} >= spd_limit);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap     <= 10'h000;
         seen    <= 1'b0;
         win_cnt <= 20'h00000;
         pcnt    <= 16'h0000;
      end else begin
         if (cmd_step) begin
            gap  <= 10'h000;
            seen <= 1'b1;
         end else if (gap != 10'h3ff) begin
            gap <= gap + 10'h001;
         end
         if (win_cnt == WIN_END) begin
            win_cnt <= 20'h00000;
            pcnt    <= 16'h0000;
         end else begin
            win_cnt <= win_cnt + 20'h00001;
            if (cmd_step && pcnt != 16'hffff)
               pcnt <= pcnt + 16'h0001;
         end
      end
   end

   // ==========================================================
   // Fault latch and drive control
   wire       dev_over   = dev_mag > dev_limit;
   wire [4:0] fault_now  = {cpu_s, posdet_s, freq_evt, spd_evt, dev_over};
   wire       cause_held = dev_over | posdet_s | cpu_s;
   wire       arst_rise  = arst_s & ~arst_d;
   reg  [4:0] next_fault;
   always @* begin
      next_fault = fault_lat | fault_now;
      // A fresh fault on the reset edge survives the clear
      if (arst_rise && !cause_held)
         next_fault = fault_now;
   end
   wire next_alarm = |next_fault;
   wire next_drive = enable_s & ~next_alarm;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_lat          <= 5'h00;
         arst_d             <= 1'b0;
         fault_n            <= 1'b0;
         motor_drive_on     <= 1'b0;
         drive_enabled_flag <= 1'b0;
      end else begin
         fault_lat          <= next_fault;
         arst_d             <= arst_s;
         fault_n            <= ~next_alarm;
         motor_drive_on     <= next_drive;
         drive_enabled_flag <= next_drive;
      end
   end

   // ==========================================================
   // Homing sequence
   wire alarm = |fault_lat;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hstate        <= H_IDLE;
         homing_done   <= 1'b0;
         homing_active <= 1'b0;
      end else begin
         case (hstate)
            H_IDLE: begin
               if (home_rq_s && motor_drive_on && !alarm) begin
                  hstate        <= H_SEEK;
                  homing_done   <= 1'b0;
                  homing_active <= 1'b1;
               end
            end
            H_SEEK: begin
               if (!home_rq_s || !motor_drive_on || alarm) begin
                  hstate        <= H_IDLE;
                  homing_active <= 1'b0;
               end else if (home_s) begin
                  hstate        <= H_DONE;
                  homing_done   <= 1'b1;
                  homing_active <= 1'b0;
               end
            end
            H_DONE: begin
               if (!home_rq_s)
                  hstate <= H_IDLE;
            end
            default: begin
               hstate        <= H_IDLE;
               homing_active <= 1'b0;
            end
         endcase
         // An alarm loses the origin; incremental position must be searched again
         if (alarm)
            homing_done <= 1'b0;
      end
   end

   // ==========================================================
   // In-position
   wire next_inpos = motor_drive_on & (dev_mag <= inpos_tol);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         in_position <= 1'b0;
      else
         in_position <= next_inpos;
   end

   // ==========================================================
   // APB slave
   wire setup  = psel & ~penable;
   wire access = psel & penable & pready;
   wire wr     = access & pwrite;
   wire rd_irq = access & ~pwrite & (paddr == `PTS_ADDR_IRQ_STAT);
   reg  [31:0] rd_mux;
   reg         hit;
   always @* begin
      hit    = 1'b1;
      rd_mux = 32'h00000000;
      case (paddr)
         `PTS_ADDR_CTRL:      rd_mux = ctrl;
         `PTS_ADDR_STATUS:    rd_mux = {19'h00000, fault_lat, 2'h0, hstate,
                                        drive_enabled_flag, fault_n, in_position,
                                        homing_done};
         `PTS_ADDR_DEV:       rd_mux = {{(32-DEV_W){dev[DEV_W-1]}}, dev};
         `PTS_ADDR_INPOS_TOL: rd_mux = inpos_tol;
         `PTS_ADDR_DEV_LIMIT: rd_mux = dev_limit;
         `PTS_ADDR_SPD_LIMIT: rd_mux = spd_limit;
         `PTS_ADDR_IRQ_STAT:  rd_mux = {29'h00000000, irq_stat};
         `PTS_ADDR_IRQ_MASK:  rd_mux = irq_mask;
         default:             hit = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         prdata    <= 32'h00000000;
         ctrl      <= `PTS_RST_CTRL;
         inpos_tol <= `PTS_RST_INPOS_TOL;
         dev_limit <= `PTS_RST_DEV_LIMIT;
         spd_limit <= `PTS_RST_SPD_LIMIT;
         irq_mask  <= `PTS_RST_IRQ_MASK;
      end else begin
         // Answer in the first access cycle; pready drops after the transfer
         pready  <= setup;
         pslverr <= setup & ~hit;
         prdata  <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
         if (wr) begin
            case (paddr)
               `PTS_ADDR_CTRL:      ctrl      <= {29'h00000000, pwdata[2:0]};
               `PTS_ADDR_INPOS_TOL: inpos_tol <= pwdata;
               `PTS_ADDR_DEV_LIMIT: dev_limit <= pwdata;
               `PTS_ADDR_SPD_LIMIT: spd_limit <= pwdata;
               `PTS_ADDR_IRQ_MASK:  irq_mask  <= {29'h00000000, pwdata[2:0]};
               default: begin
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Interrupts
   reg        alarm_d;
   reg        hdone_d;
   reg        inpos_d;
   wire [2:0] irq_evt = {in_position & ~inpos_d, homing_done & ~hdone_d, alarm & ~alarm_d};
   // Clear only the bits the read returned; an event after the data was taken stays set
   wire [2:0] next_irq_stat = ((rd_irq ? ~prdata[2:0] : 3'h7) & irq_stat) | irq_evt;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= 3'h0;
         alarm_d  <= 1'b0;
         hdone_d  <= 1'b0;
         inpos_d  <= 1'b0;
         irq      <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         alarm_d  <= alarm;
         hdone_d  <= homing_done;
         inpos_d  <= in_position;
         irq      <= |(next_irq_stat & irq_mask[2:0]);
      end
   end
endmodule

// [pts_defs.vh]
// Constants for the pulse train servo I/O block
// Behaviour
// - Decode quadrature, step/sign or CW/CCW pulses
// - Differential uses positive pins; single-ended uses negative
// - Homing runs while request held, aborts otherwise
// - Drive energized only while enable input asserted
// - Homing done asserted after successful origin search
// - In-position while deviation within tolerance; code also needs drive energized
// - Fault output high normally, low on alarm
// - Drive status flag follows energized drive
// - Every detected fault raises the alarm
`ifndef PTS_DEFS_VH
`define PTS_DEFS_VH

// ==========================================================
// Register offsets
`define PTS_ADDR_CTRL      8'h00
`define PTS_ADDR_STATUS    8'h04
`define PTS_ADDR_DEV       8'h08
`define PTS_ADDR_INPOS_TOL 8'h0c
`define PTS_ADDR_DEV_LIMIT 8'h10
`define PTS_ADDR_SPD_LIMIT 8'h14
`define PTS_ADDR_IRQ_STAT  8'h18
`define PTS_ADDR_IRQ_MASK  8'h1c

// ==========================================================
// Field positions
`define PTS_CTRL_FMT_LO    0
`define PTS_CTRL_FMT_HI    1
`define PTS_CTRL_SE        2
`define PTS_ST_FAULT_LO    8
`define PTS_ST_FAULT_HI    12

// ==========================================================
// Pulse formats
`define PTS_FMT_QUAD       2'h0
`define PTS_FMT_STEP_SIGN  2'h1
`define PTS_FMT_CW_CCW     2'h2

// ==========================================================
// Reset values
`define PTS_RST_CTRL       32'h00000000
`define PTS_RST_INPOS_TOL  32'h0000000a
`define PTS_RST_DEV_LIMIT  32'h00001000
`define PTS_RST_SPD_LIMIT  32'h00000200
`define PTS_RST_IRQ_MASK   32'h00000000

// ==========================================================
// Timing
`define PTS_CLK_KHZ        100000
`define PTS_DIFF_MAX_KPPS  500
`define PTS_SE_MAX_KPPS    100
`define PTS_DIFF_MIN_CYC   (`PTS_CLK_KHZ / `PTS_DIFF_MAX_KPPS)
`define PTS_SE_MIN_CYC     (`PTS_CLK_KHZ / `PTS_SE_MAX_KPPS)
// One millisecond window, sized to fit the 20-bit window counter
`define PTS_SPEED_WIN_US   1000
`define PTS_SPEED_WIN_CYC  20'h186a0

`endif

// [pts_sync.v]
// Two-stage synchroniser for asynchronous pin inputs
module pts_sync #(
   parameter W = 1
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);

   // ==========================================================
   // Per-bit flop pair
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg s1;
         reg s2;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
            end else begin
               s1 <= d[i];
               s2 <= s1;
            end
         end
         assign q[i] = s2;
      end
   endgenerate
endmodule

// [pts_decode.v]
// Pulse format decoder: one-cycle step pulse with direction
`include "pts_defs.vh"
module pts_decode (
   input  wire       pclk,
   input  wire       presetn,
   input  wire [1:0] fmt,
   input  wire       a,
   input  wire       b,
   output reg        step,
   output reg        dir
);

   reg a_d;
   reg b_d;

   // ==========================================================
   // Edge decode
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_d  <= 1'b0;
         b_d  <= 1'b0;
         step <= 1'b0;
         dir  <= 1'b0;
      end else begin
         a_d <= a;
         b_d <= b;
         case (fmt)
            `PTS_FMT_STEP_SIGN: begin
               step <= a & ~a_d;
               dir  <= b;
            end
            `PTS_FMT_CW_CCW: begin
               step <= (a & ~a_d) ^ (b & ~b_d);
               dir  <= a & ~a_d;
            end
            default: begin
               // Times-four decode; a double edge is an illegal jump and is dropped
               step <= (a ^ a_d) ^ (b ^ b_d);
               dir  <= (a ^ a_d) ? (a ^ b) : ~(a ^ b);
            end
         endcase
      end
   end
endmodule

// [pts_top_chk.sv]
// Port checker for the pulse train servo I/O block
module pts_top_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic drive_enable_input,
   input wire logic motor_drive_on,
   input wire logic drive_enabled_flag,
   input wire logic fault_n,
   input wire logic in_position,
   input wire logic homing_request,
   input wire logic homing_active,
   input wire logic homing_done,
   input wire logic cpu_fault_in,
   input wire logic alarm_reset_input
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====
   // Properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_flag_drive: assert property (drive_enabled_flag == motor_drive_on)
      else $error("drive flag differs from drive");
   // Six cycles cover the pin synchroniser and the drive output register
   a_drive_off: assert property (!drive_enable_input [*6] |-> !motor_drive_on)
      else $error("drive on without enable");
   a_alarm_stops: assert property (!fault_n [*3] |-> !motor_drive_on)
      else $error("drive on during alarm");
   a_inpos_drive: assert property (!motor_drive_on [*2] |-> !in_position)
      else $error("in position with drive off");
   a_homing_req: assert property (!homing_request [*5] |-> !homing_active)
      else $error("search runs without request");
   a_done_idle: assert property (homing_done |-> !homing_active)
      else $error("done while searching");
   a_cpu_alarm: assert property (cpu_fault_in [*6] |-> !fault_n)
      else $error("cpu fault without alarm");
   a_alarm_held: assert property (!alarm_reset_input [*6] ##0 !fault_n |=> !fault_n)
      else $error("alarm cleared without reset");
   c_alarm: cover property ($fell(fault_n));
   c_home: cover property ($rose(homing_done));
   c_inpos: cover property ($rose(in_position));
endmodule

bind pts_top pts_top_chk i_pts_top_chk (
   .pclk(pclk), .presetn(presetn), .drive_enable_input(drive_enable_input),
   .motor_drive_on(motor_drive_on), .drive_enabled_flag(drive_enabled_flag),
   .fault_n(fault_n), .in_position(in_position), .homing_request(homing_request),
   .homing_active(homing_active), .homing_done(homing_done),
   .cpu_fault_in(cpu_fault_in), .alarm_reset_input(alarm_reset_input)
);

// [pts_pulse_gen.sv]
// Command pulse source model driving the step and heading pins
`include "pts_defs.vh"
module pts_pulse_gen (
   input  wire logic        pclk,
   input  wire logic        go,
   input  wire logic        back,
   input  wire logic [1:0]  fmt,
   input  wire logic        se,
   input  wire logic [15:0] gap,
   output logic             step_in_pos,
   output logic             step_in_neg,
   output logic             heading_in_pos,
   output logic             heading_in_neg,
   output logic             busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       a = 1'b0;
   logic       b = 1'b0;
   logic       noise = 1'b0;
   logic [1:0] ph = 2'h0;
   initial busy = 1'b0;
   // =====
   // Pins: positive side is unconnected in single-ended use, so it floats
   always @(posedge pclk) noise <= ~noise;
   assign step_in_pos    = se ? noise : a;
   assign heading_in_pos = se ? ~noise : b;
   assign step_in_neg    = ~a;
   assign heading_in_neg = ~b;
   task automatic hold();
      repeat (gap) @(posedge pclk);
   endtask
   // =====
   // One command step per request
   always begin
      @(posedge pclk);
      if (go) begin
         busy <= 1'b1;
         if (fmt == `PTS_FMT_QUAD) begin
            ph = back ? ph - 2'h1 : ph + 2'h1;
            a <= ph[1] ^ ph[0];
            b <= ph[1];
            hold();
         end else begin
            if (a | b) begin
               a <= 1'b0;
               b <= 1'b0;
               ph = 2'h0;
               hold();
            end
            if (fmt == `PTS_FMT_STEP_SIGN) begin
               b <= back;
               hold();
            end
            if (fmt == `PTS_FMT_CW_CCW && back) begin
               b <= 1'b1;
               hold();
               b <= 1'b0;
            end else begin
               a <= 1'b1;
               hold();
               a <= 1'b0;
            end
            hold();
         end
         busy <= 1'b0;
      end
   end
endmodule

// [test_pulse_train_servo_io.sv]
// Self-checking bench for the pulse train servo I/O block
`include "pts_defs.vh"
module test_pulse_train_servo_io;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, q;
   logic        e, neg, go = 0, back = 0, se = 0, busy;
   logic [1:0]  fmt = 2'h0, fb = 2'h0;
   logic [15:0] gap = 16'd210;
   logic        homing_request = 0, alarm_reset_input = 0, drive_enable_input = 0;
   logic        feedback_a = 0, feedback_b = 0, home_sensor_in = 0;
   logic        sensor_fault_in = 0, cpu_fault_in = 0;
   wire  [31:0] prdata;
   wire         pready, pslverr, homing_done, homing_active, in_position, fault_n;
   wire         drive_enabled_flag, motor_drive_on, irq;
   wire         step_in_pos, step_in_neg, heading_in_pos, heading_in_neg;
   int          fail_count = 0, n_checks = 0;
   always #5 pclk = ~pclk;
   pts_top #(.SPEED_WIN(20'd200)) i_pts_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .step_in_pos(step_in_pos), .step_in_neg(step_in_neg), .heading_in_pos(heading_in_pos),
      .heading_in_neg(heading_in_neg), .homing_request(homing_request),
      .alarm_reset_input(alarm_reset_input), .drive_enable_input(drive_enable_input),
      .feedback_a(feedback_a), .feedback_b(feedback_b), .home_sensor_in(home_sensor_in),
      .sensor_fault_in(sensor_fault_in), .cpu_fault_in(cpu_fault_in),
      .homing_done(homing_done), .homing_active(homing_active), .in_position(in_position),
      .fault_n(fault_n), .drive_enabled_flag(drive_enabled_flag),
      .motor_drive_on(motor_drive_on), .irq(irq));
   pts_pulse_gen i_pts_pulse_gen (
      .pclk(pclk), .go(go), .back(back), .fmt(fmt), .se(se), .gap(gap),
      .step_in_pos(step_in_pos), .step_in_neg(step_in_neg), .heading_in_pos(heading_in_pos),
      .heading_in_neg(heading_in_neg), .busy(busy));
   // =====
   // Tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, s, x);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask
   task automatic tmo(input int k);
      if (k >= 9000) begin
         fail_count++;
         $display("CHECK FAILED at %0t: wait timed out", $time);
         conclude();
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 9000);
      tmo(k);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q & m, x);
   endtask
   task automatic send(input logic bk);
      int k;
      back <= bk;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (busy === 1'b1 && k < 9000);
      tmo(k);
   endtask
   task automatic feed(input logic bk);
      fb = bk ? fb - 2'h1 : fb + 2'h1;
      feedback_a <= fb[1] ^ fb[0];
      feedback_b <= fb[1];
      cyc(8);
   endtask
   task automatic clr();
      alarm_reset_input <= 1'b1;
      cyc(8);
      alarm_reset_input <= 1'b0;
      cyc(8);
   endtask
   // =====
   // Sequence
   initial begin
      cyc(12);
      presetn <= 1'b1;
      cyc(3);
      chk(fault_n, 1'b1);
      rd(`PTS_ADDR_INPOS_TOL, '1, `PTS_RST_INPOS_TOL);
      rd(`PTS_ADDR_SPD_LIMIT, '1, `PTS_RST_SPD_LIMIT);
      rd(8'h20, '1, 32'h0);
      chk(e, 1'b1);
      for (int f = 0; f < 3; f++)
         for (int s = 0; s < 2; s++) begin
            drive_enable_input <= 1'b0;
            cyc(8);
            chk(drive_enabled_flag, 1'b0);
            // Floating positive pins must not be seen while the decoder uses them
            if (s == 0)
               se <= 1'b0;
            fmt <= f[1:0];
            wr_ctrl: apb(1'b1, `PTS_ADDR_CTRL, {29'h0, s[0], f[1:0]});
            se <= s[0];
            gap <= s ? `PTS_SE_MIN_CYC + 10 : `PTS_DIFF_MIN_CYC + 10;
            drive_enable_input <= 1'b1;
            // The single-ended spacing also counts from the last step of the previous pass
            cyc(s ? 1000 : 8);
            chk(motor_drive_on, 1'b1);
            send(1'b0);
            send(1'b0);
            send(1'b1);
            cyc(6);
            apb(1'b0, `PTS_ADDR_DEV, 32'h0);
            // Sign level polarity is open, so step/sign is judged on magnitude
            neg = (f == 1) && q[23];
            if (neg)
               q = -q;
            chk(q & 32'hffffff, 32'h1);
            feed(neg);
            rd(`PTS_ADDR_DEV, 32'hffffff, 32'h0);
            chk(in_position, 1'b1);
         end
      gap <= 16'd300;
      // A lone step after a long pause cannot trip the monitor; the second comes too soon
      send(1'b0);
      send(1'b0);
      cyc(6);
      chk(fault_n, 1'b0);
      rd(`PTS_ADDR_STATUS, 32'h400, 32'h400);
      chk(irq, 1'b0);
      apb(1'b1, `PTS_ADDR_IRQ_MASK, 32'h1);
      cyc(2);
      chk(irq, 1'b1);
      rd(`PTS_ADDR_IRQ_STAT, 32'h1, 32'h1);
      cyc(2);
      chk(irq, 1'b0);
      clr();
      chk(fault_n, 1'b1);
      for (int k = 0; k < 2; k++) begin
         sensor_fault_in <= k[0];
         cpu_fault_in <= !k[0];
         cyc(8);
         chk(fault_n, 1'b0);
         rd(`PTS_ADDR_STATUS, 32'h1800, k ? 32'h800 : 32'h1000);
         clr();
         chk(fault_n, 1'b0);
         sensor_fault_in <= 1'b0;
         cpu_fault_in <= 1'b0;
         clr();
         chk(fault_n, 1'b1);
      end
      homing_request <= 1'b1;
      cyc(8);
      chk(homing_active, 1'b1);
      homing_request <= 1'b0;
      cyc(8);
      chk(homing_active | homing_done, 1'b0);
      homing_request <= 1'b1;
      cyc(8);
      home_sensor_in <= 1'b1;
      cyc(8);
      chk({homing_done, homing_active}, 2'h2);
      homing_request <= 1'b0;
      se <= 1'b0;
      fmt <= 2'h0;
      gap <= 16'd210;
      apb(1'b1, `PTS_ADDR_CTRL, 32'h0);
      apb(1'b1, `PTS_ADDR_INPOS_TOL, 32'h0);
      send(1'b0);
      cyc(6);
      chk(in_position, 1'b0);
      feed(1'b0);
      chk(in_position, 1'b1);
      conclude();
   end
endmodule
